// ==== core/tco_defines.svh ====
// Constants for the timer 2 clock-output block: register indices, bit positions, reset values and prescale counts.
// Assumes inclusion by the core only.
// How it works
// - Clock-out wave has fifty percent duty cycle
// - Clock-out mode counts at half oscillator rate
// - Overflow reloads count from reload pair, except in capture mode without baud or clock-out, where it wraps to zero
// - Clock-out overflows raise no interrupt
// - Output frequency is osc/(4*(65536-reload))
// - Generated clock drives shared count pin
// - Baud and clock-out share reload pair
// - Timer advances only while run bit set
// - Trigger falling edge sets external flag
// - External flag interrupts except in up/down
// - Bit 5 picks receive serial clock
// - Bit 4 picks transmit serial clock
// - Select bit picks oscillator or pin edges
// - Control resets to zero, bits individually writable
// - Output enable turns count pin into output
`ifndef TCO_DEFINES_SVH
`define TCO_DEFINES_SVH

// -----------------------------------------------------------------
// Register indices, byte address is four times the index
// -----------------------------------------------------------------
`define TCO_IDX_CTRL 8'hC8
`define TCO_IDX_MODE 8'hC9
`define TCO_IDX_RLD_LO 8'hCA
`define TCO_IDX_RLD_HI 8'hCB
`define TCO_IDX_CNT_LO 8'hCC
`define TCO_IDX_CNT_HI 8'hCD
`define TCO_IDX_IRQ_STAT 8'hCE
`define TCO_IDX_IRQ_MASK 8'hCF

// -----------------------------------------------------------------
// Control register bits
// -----------------------------------------------------------------
`define TCO_B_OVF 7
`define TCO_B_EXF 6
`define TCO_B_RCLK 5
`define TCO_B_TX_CLOCK_SELECT 4
`define TCO_B_EXEN 3
`define TCO_B_RUN 2
`define TCO_B_CTS 1
`define TCO_B_CPRL 0
`define TCO_CTRL_RST 8'h00

// Mode register bits
`define TCO_B_OE 1
`define TCO_B_UP_DOWN_ENABLE 0

// Interrupt status bits
`define TCO_I_OVF 0
`define TCO_I_EXT 1

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define TCO_FOSC_MHZ 100
`define TCO_DIV_FAST 4'h2
`define TCO_DIV_SLOW 4'hC
`define TCO_CNT_MAX 16'hFFFF

`endif

// ==== core/tco_pkg.sv ====
// Types for the timer 2 clock-output block.
// Assumes tco_defines.svh is on the include path.
package tco_pkg;

  typedef struct packed {
    logic dph_wr;
    logic [7:0] dph_idx;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic oe;
    logic up_down_enable;
    logic [15:0] reload;
    logic [15:0] count;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [3:0] presc;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic clk_out;
    logic ovf_p;
    logic rx_tick;
    logic tx_tick;
  } tco_state_t;

endpackage : tco_pkg

// ==== core/tco_timer2.sv ====
// Timer 2 with programmable clock output, AHB-Lite register slave.
// Assumes one clock, synchronous active-low reset, a single word-only AHB-Lite master.
//
// The AHB-Lite slave port was chosen for this implementation.
`include "tco_defines.svh"

module tco_timer2
  import tco_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic count_pin_i,
  output logic count_pin_o,
  output logic count_pin_oe_n_o,
  input wire logic trigger_pin_i,
  input wire logic timer1_ovf_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  output logic timer2_ovf_o,
  output logic irq_o
);

  tco_state_t s_q;
  tco_state_t s_d;

  logic baud;
  logic fast;
  logic tick;
  logic inc;
  logic ovf;
  logic trig_fall;
  logic pin_fall;
  logic trig_ev;
  logic wr_ctrl;
  logic wr_cnt;
  logic [3:0] div;

  // -----------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------
  // Only the lowest kilobyte is mapped, anything above reads as zero
  function automatic logic addr_ok(input logic [31:0] a);
    return a[31:10] == 22'h000000;
  endfunction : addr_ok

  // Data-phase write aimed at one register
  function automatic logic wr_hit(input tco_state_t s, input logic [7:0] idx);
    return s.dph_wr && (s.dph_idx == idx);
  endfunction : wr_hit

  // -----------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // -----------------------------------------------------------------
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_q.rdata;

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Synchronisers, third stage only for edge detection
    s_d.trig_s1 = trigger_pin_i;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_s3 = s_q.trig_s2;
    s_d.pin_s1 = count_pin_i;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_s3 = s_q.pin_s2;
    trig_fall = s_q.trig_s3 & ~s_q.trig_s2;
    pin_fall = s_q.pin_s3 & ~s_q.pin_s2;

    baud = s_q.ctrl[`TCO_B_RCLK] | s_q.ctrl[`TCO_B_TX_CLOCK_SELECT];
    fast = s_q.oe | baud;
    div = fast ? `TCO_DIV_FAST : `TCO_DIV_SLOW;
    tick = s_q.ctrl[`TCO_B_RUN] && (s_q.presc == div - 4'h1);
    if (!s_q.ctrl[`TCO_B_RUN] || tick) begin
      s_d.presc = 4'h0;
    end else begin
      s_d.presc = s_q.presc + 4'h1;
    end
    // Pin edges in counter mode, prescaled oscillator otherwise
    inc = s_q.ctrl[`TCO_B_RUN] && (s_q.ctrl[`TCO_B_CTS] ? pin_fall : tick);
    ovf = inc && (s_q.count == `TCO_CNT_MAX);
    // Trigger edges raise no event while up/down mode is set; the count still only counts up
    trig_ev = trig_fall & s_q.ctrl[`TCO_B_EXEN] & ~s_q.up_down_enable;

    // Register writes in the data phase
    wr_ctrl = wr_hit(s_q, `TCO_IDX_CTRL);
    wr_cnt = wr_hit(s_q, `TCO_IDX_CNT_LO) || wr_hit(s_q, `TCO_IDX_CNT_HI);
    if (s_q.dph_wr) begin
      unique case (s_q.dph_idx)
        `TCO_IDX_CTRL: s_d.ctrl = hwdata_i[7:0];
        `TCO_IDX_MODE: begin
          s_d.oe = hwdata_i[`TCO_B_OE];
          s_d.up_down_enable = hwdata_i[`TCO_B_UP_DOWN_ENABLE];
        end
        `TCO_IDX_RLD_LO: s_d.reload[7:0] = hwdata_i[7:0];
        `TCO_IDX_RLD_HI: s_d.reload[15:8] = hwdata_i[7:0];
        `TCO_IDX_CNT_LO: s_d.count[7:0] = hwdata_i[7:0];
        `TCO_IDX_CNT_HI: s_d.count[15:8] = hwdata_i[7:0];
        `TCO_IDX_IRQ_STAT: s_d.istat = s_q.istat & ~hwdata_i[1:0];
        `TCO_IDX_IRQ_MASK: s_d.imask = hwdata_i[1:0];
        default: ;
      endcase
    end

    // Hardware after software: a set in the same cycle wins
    if (ovf && (baud || s_q.oe || !s_q.ctrl[`TCO_B_CPRL])) begin
      s_d.count = s_q.reload;
    end else if (trig_ev && !baud && !s_q.ctrl[`TCO_B_CPRL]) begin
      s_d.count = s_q.reload;
    end else if (inc) begin
      s_d.count = s_q.count + 16'h0001;
    end
    if (trig_ev && !baud && s_q.ctrl[`TCO_B_CPRL]) begin
      s_d.reload = s_q.count;
    end
    if (trig_ev) begin
      s_d.ctrl[`TCO_B_EXF] = 1'b1;
      s_d.istat[`TCO_I_EXT] = 1'b1;
    end
    // No overflow flag while serial clocks or clock output use it
    if (ovf && !baud && !s_q.oe) begin
      s_d.ctrl[`TCO_B_OVF] = 1'b1;
      s_d.istat[`TCO_I_OVF] = 1'b1;
    end

    // Toggle per overflow: half period is 2*(65536-reload) clocks
    if (!s_q.oe) begin
      s_d.clk_out = 1'b0;
    end else if (ovf) begin
      s_d.clk_out = ~s_q.clk_out;
    end
    s_d.ovf_p = ovf;
    s_d.rx_tick = s_q.ctrl[`TCO_B_RCLK] ? ovf : timer1_ovf_i;
    s_d.tx_tick = s_q.ctrl[`TCO_B_TX_CLOCK_SELECT] ? ovf : timer1_ovf_i;

    // Address phase: capture write target, latch read data
    s_d.dph_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_d.dph_wr = hwrite_i && addr_ok(haddr_i);
      s_d.dph_idx = haddr_i[9:2];
      s_d.rdata = 32'h00000000;
      if (!hwrite_i && addr_ok(haddr_i)) begin
        unique case (haddr_i[9:2])
          `TCO_IDX_CTRL: s_d.rdata[7:0] = s_q.ctrl;
          `TCO_IDX_MODE: s_d.rdata[1:0] = {s_q.oe, s_q.up_down_enable};
          `TCO_IDX_RLD_LO: s_d.rdata[7:0] = s_q.reload[7:0];
          `TCO_IDX_RLD_HI: s_d.rdata[7:0] = s_q.reload[15:8];
          `TCO_IDX_CNT_LO: s_d.rdata[7:0] = s_q.count[7:0];
          `TCO_IDX_CNT_HI: s_d.rdata[7:0] = s_q.count[15:8];
          `TCO_IDX_IRQ_STAT: s_d.rdata[1:0] = s_q.istat;
          `TCO_IDX_IRQ_MASK: s_d.rdata[1:0] = s_q.imask;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign count_pin_o = s_q.clk_out;
  assign count_pin_oe_n_o = ~s_q.oe;
  assign timer2_ovf_o = s_q.ovf_p;
  assign rx_baud_tick_o = s_q.rx_tick;
  assign tx_baud_tick_o = s_q.tx_tick;
  assign irq_o = |(s_q.istat & s_q.imask);

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  logic wr_stat;
  logic wr_mask;
  logic wr_mode;
  logic wr_rld;
  logic take;
  assign wr_stat = wr_hit(s_q, `TCO_IDX_IRQ_STAT);
  assign wr_mask = wr_hit(s_q, `TCO_IDX_IRQ_MASK);
  assign wr_mode = wr_hit(s_q, `TCO_IDX_MODE);
  assign wr_rld = wr_hit(s_q, `TCO_IDX_RLD_LO) || wr_hit(s_q, `TCO_IDX_RLD_HI);
  assign take = hsel_i && hready_i && htrans_i[1];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  AST_BUS_OKAY: assert property (
    hreadyout_o && !hresp_o
  ) else $error("bus slave inserted a wait or an error");

  AST_HRDATA_HOLD: assert property (
    !take |=> $stable(hrdata_o)
  ) else $error("read data moved outside an address phase");

  AST_READ_CTRL: assert property (
    take && !hwrite_i && addr_ok(haddr_i) && haddr_i[9:2] == `TCO_IDX_CTRL |=> hrdata_o == {24'h000000, $past(s_q.ctrl)}
  ) else $error("control read returned wrong data");

  AST_CTRL_WRITE: assert property (
    wr_ctrl && !trig_ev && !ovf |=> s_q.ctrl == $past(hwdata_i[7:0])
  ) else $error("control write did not land");

  AST_RESET_CLEAR: assert property (
    disable iff (1'b0) !rst_n_i |=> s_q.ctrl == `TCO_CTRL_RST && !s_q.oe && !irq_o
  ) else $error("reset did not clear control");

  AST_OE_WRITE: assert property (
    wr_mode |=> count_pin_oe_n_o == !$past(hwdata_i[`TCO_B_OE])
  ) else $error("pin direction does not follow output enable");

  AST_CLK_IDLE: assert property (
    !s_q.oe && $past(!s_q.oe) |-> !count_pin_o
  ) else $error("clock output active while disabled");

  AST_TOGGLE_OVF: assert property (
    s_q.oe && $past(s_q.oe) && s_q.ovf_p |-> $changed(count_pin_o)
  ) else $error("overflow did not toggle clock output");

  AST_COUNT_INC: assert property (
    inc && !ovf && !wr_cnt && !trig_ev |=> s_q.count == $past(s_q.count) + 16'h0001
  ) else $error("count did not advance by one");

  AST_RUN_GATE: assert property (
    !s_q.ctrl[`TCO_B_RUN] |-> !inc ##1 s_q.presc == 4'h0
  ) else $error("prescaler or count active while stopped");

  AST_WRAP_CAPTURE: assert property (
    ovf && !baud && !s_q.oe && s_q.ctrl[`TCO_B_CPRL] && !wr_cnt |=> s_q.count == 16'h0000
  ) else $error("capture mode overflow did not wrap");

  AST_TRIG_RELOAD: assert property (
    trig_ev && !baud && !s_q.ctrl[`TCO_B_CPRL] |=> s_q.count == $past(s_q.reload)
  ) else $error("trigger did not reload count");

  AST_BAUD_NO_CAPTURE: assert property (
    trig_ev && baud && !wr_rld |=> $stable(s_q.reload)
  ) else $error("trigger captured in baud mode");

  AST_BAUD_RELOAD: assert property (
    ovf && baud |=> s_q.count == $past(s_q.reload)
  ) else $error("baud overflow did not reload count");

  AST_UPDOWN_NO_TRIG: assert property (
    trig_fall && s_q.up_down_enable && !wr_ctrl |=> $stable(s_q.ctrl[`TCO_B_EXF])
  ) else $error("trigger flagged in up/down mode");

  AST_IRQ_SOURCE: assert property (
    $rose(irq_o) |-> $past(trig_ev || ovf || wr_mask)
  ) else $error("interrupt rose without a cause");

  AST_STICKY_EXT: assert property (
    s_q.ctrl[`TCO_B_EXF] && !wr_ctrl |=> s_q.ctrl[`TCO_B_EXF]
  ) else $error("external flag cleared by hardware");

  AST_STAT_CLEAR: assert property (
    wr_stat && !trig_ev && !ovf |=> s_q.istat == ($past(s_q.istat) & ~$past(hwdata_i[1:0]))
  ) else $error("status write did not clear by ones");

  AST_STICKY_OVF: assert property (
    s_q.ctrl[`TCO_B_OVF] && !wr_ctrl |=> s_q.ctrl[`TCO_B_OVF]
  ) else $error("overflow flag cleared by hardware");

  AST_BAUD_NO_FLAG: assert property (
    ovf && baud && !wr_ctrl |=> $stable(s_q.ctrl[`TCO_B_OVF])
  ) else $error("baud overflow set the overflow flag");

  AST_TX_SEL: assert property (
    s_q.ctrl[`TCO_B_TX_CLOCK_SELECT] && $stable(s_q.ctrl[`TCO_B_TX_CLOCK_SELECT]) |-> tx_baud_tick_o == $past(ovf)
  ) else $error("transmit clock not from timer 2");

  AST_RX_T1: assert property (
    !s_q.ctrl[`TCO_B_RCLK] && $stable(s_q.ctrl[`TCO_B_RCLK]) |-> rx_baud_tick_o == $past(timer1_ovf_i)
  ) else $error("receive clock not from timer 1");

  AST_TX_T1: assert property (
    !s_q.ctrl[`TCO_B_TX_CLOCK_SELECT] && $stable(s_q.ctrl[`TCO_B_TX_CLOCK_SELECT]) |-> tx_baud_tick_o == $past(timer1_ovf_i)
  ) else $error("transmit clock not from timer 1");

  AST_DUTY: assert property (
    $changed(s_q.clk_out) && s_q.oe && $past(s_q.oe) |-> s_q.ovf_p
  ) else $error("clock output toggled without overflow");

  AST_HALF_RATE: assert property (
    inc && s_q.oe && !s_q.ctrl[`TCO_B_CTS] |=> !inc ##1 (inc || !s_q.ctrl[`TCO_B_RUN] || !s_q.oe || wr_ctrl)
  ) else $error("clock-out count not at half rate");

  AST_RELOAD: assert property (
    ovf && s_q.oe |=> s_q.count == $past(s_q.reload)
  ) else $error("overflow did not reload count");

  AST_NO_IRQ: assert property (
    ovf && s_q.oe && !wr_ctrl && !wr_stat |=> $stable(s_q.ctrl[`TCO_B_OVF]) && $stable(s_q.istat[`TCO_I_OVF])
  ) else $error("clock-out overflow set a flag");

  AST_STOPPED: assert property (
    !s_q.ctrl[`TCO_B_RUN] && !wr_cnt && !trig_ev |=> $stable(s_q.count)
  ) else $error("count moved while stopped");

  AST_EXT_FLAG: assert property (
    trig_ev |=> s_q.ctrl[`TCO_B_EXF] && s_q.istat[`TCO_I_EXT]
  ) else $error("trigger edge did not set external flag");

  AST_OVF_FLAG: assert property (
    ovf && !baud && !s_q.oe |=> s_q.ctrl[`TCO_B_OVF] && s_q.istat[`TCO_I_OVF]
  ) else $error("overflow flag not set");

  AST_PIN_COUNT: assert property (
    s_q.ctrl[`TCO_B_CTS] && !pin_fall |-> !inc
  ) else $error("counter advanced without pin edge");

  AST_CAPTURE: assert property (
    trig_ev && !baud && s_q.ctrl[`TCO_B_CPRL] |=> s_q.reload == $past(s_q.count)
  ) else $error("trigger did not capture count");

  AST_RX_SEL: assert property (
    s_q.ctrl[`TCO_B_RCLK] && $stable(s_q.ctrl[`TCO_B_RCLK]) |-> rx_baud_tick_o == $past(ovf)
  ) else $error("receive clock not from timer 2");

  COV_CLKOUT_TOGGLE: cover property (s_q.oe && ovf ##1 $changed(count_pin_o));
  COV_CAPTURE: cover property (trig_ev && s_q.ctrl[`TCO_B_CPRL]);
  COV_IRQ: cover property ($rose(irq_o));
  COV_BAUD_TICK: cover property (s_q.ctrl[`TCO_B_RCLK] && rx_baud_tick_o);
  COV_PIN_COUNT: cover property (s_q.ctrl[`TCO_B_CTS] && inc);

endmodule : tco_timer2

// ==== tb/tco_pin_model.sv ====
// Far side of the timer: count pin source, trigger pin and timer 1 overflow.
// Assumes one shared clock and bench requests that last one cycle.
module tco_pin_model (
  input wire logic mclk_i,
  input wire logic edge_req_i,
  input wire logic trig_req_i,
  output logic pin_o,
  output logic trig_o,
  output logic t1_ovf_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int pc = 0;
  int tc = 0;
  int t1 = 0;
  // Low pulses of four cycles, else the pull-up level
  always @(posedge mclk_i) begin
    pc <= edge_req_i ? 8 : (pc > 0 ? pc - 1 : 0);
    tc <= trig_req_i ? 8 : (tc > 0 ? tc - 1 : 0);
    t1 <= (t1 == 6) ? 0 : t1 + 1;
  end
  assign pin_o = !(pc > 4);
  assign trig_o = !(tc > 4);
  assign t1_ovf_o = (t1 == 6);
endmodule : tco_pin_model

// ==== tb/testbench.sv ====
// Self-checking bench for the timer 2 clock-output block.
// Assumes the pin model on the far side and a single AHB-Lite master here.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, hwrite = 0, ereq = 0, treq = 0, rd_dph = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h2D;
  logic hready, dut_pin, oe_n, mdl_pin, trig, t1o, rxt, txt, t2o, irq;
  logic [31:0] exp_q[$];
  int fail_count = 0, comparisons = 0;
  wire logic pin_w = oe_n ? mdl_pin : dut_pin;
  tco_timer2 i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(), .hrdata_o(hrdata), .count_pin_i(pin_w), .count_pin_o(dut_pin), .count_pin_oe_n_o(oe_n),
    .trigger_pin_i(trig), .timer1_ovf_i(t1o), .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt),
    .timer2_ovf_o(t2o), .irq_o(irq));
  tco_pin_model i_mdl (.mclk_i(mclk), .edge_req_i(ereq), .trig_req_i(treq), .pin_o(mdl_pin),
    .trig_o(trig), .t1_ovf_o(t1o));
  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Read data is judged by the monitor, at the edge that ends the data phase
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) exp_q.push_back(d);
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
  endtask : bus
  always @(posedge mclk) begin
    if (rd_dph && hready) begin
      cmp(hrdata, exp_q.pop_front());
    end
    if (hready) begin
      rd_dph <= htrans[1] && !hwrite;
    end
  end
  // Cycles until pin toggle (0), rx tick (1), tx tick (2) or overflow (3); 300 means none
  task automatic gap(input int w, output int n);
    logic p;
    p = dut_pin;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (n < 300 && !(w == 0 ? dut_pin !== p : w == 1 ? rxt === 1'b1 : w == 2 ? txt === 1'b1 : t2o === 1'b1));
  endtask : gap
  // First gap is discarded: it starts at an arbitrary phase
  task automatic per(input int w, input int e);
    int n;
    gap(w, n);
    gap(w, n);
    cmp(n, e);
    gap(w, n);
    cmp(n, e);
  endtask : per
  task automatic pulse(input logic e, input logic t);
    ereq <= e;
    treq <= t;
    @(posedge mclk);
    ereq <= 0;
    treq <= 0;
    repeat (10) @(posedge mclk);
  endtask : pulse
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    wrap_up();
  end
  // -----------------------------------------------------------------
  // Sequence
  // -----------------------------------------------------------------
  initial begin
    int n;
    logic [15:0] r;
    repeat (16) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    cmp({oe_n, irq, dut_pin}, 3'h4);
    bus(0, 8'hC8, 32'h00);
    bus(1, 8'hD0, 32'hFF);
    bus(0, 8'hD0, 32'h00);
    for (int i = 0; i < 6; i++) begin
      bus(1, 8'hC8, 32'h1 << i);
      bus(0, 8'hC8, 32'h1 << i);
    end
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      r = {12'hFFF, seed[3:0]};
      bus(1, 8'hC9, 32'h02);
      bus(1, 8'hC8, 32'h00);
      bus(1, 8'hCA, {24'h0, r[7:0]});
      bus(1, 8'hCB, {24'h0, r[15:8]});
      bus(1, 8'hCC, {24'h0, 4'hF, seed[7:4]});
      bus(1, 8'hCD, 32'hFF);
      bus(1, 8'hC8, 32'h04);
      per(0, 2 * (32'h10000 - r));
    end
    cmp({oe_n, irq}, 2'h0);
    bus(0, 8'hC8, 32'h04);
    bus(0, 8'hCE, 32'h00);
    bus(1, 8'hC8, 32'h24);
    per(1, 2 * (32'h10000 - r));
    per(0, 2 * (32'h10000 - r));
    per(2, 7);
    bus(1, 8'hC8, 32'h14);
    per(2, 2 * (32'h10000 - r));
    per(1, 7);
    bus(0, 8'hC8, 32'h14);
    bus(1, 8'hC8, 32'h00);
    gap(0, n);
    gap(0, n);
    cmp(n, 300);
    bus(1, 8'hC9, 32'h00);
    bus(1, 8'hCA, 32'hFE);
    bus(1, 8'hCF, 32'h01);
    bus(1, 8'hC8, 32'h04);
    per(3, 24);
    bus(0, 8'hC8, 32'h84);
    cmp(irq, 32'h1);
    bus(1, 8'hC8, 32'h00);
    bus(1, 8'hCE, 32'h01);
    bus(0, 8'hCE, 32'h00);
    cmp(irq, 32'h0);
    bus(0, 8'hC8, 32'h00);
    bus(1, 8'hCA, 32'h34);
    bus(1, 8'hCB, 32'h12);
    bus(1, 8'hCC, 32'hFE);
    bus(1, 8'hCD, 32'hFF);
    bus(1, 8'hC8, 32'h06);
    bus(0, 8'hCC, 32'hFE);
    pulse(1, 0);
    bus(0, 8'hCC, 32'hFF);
    pulse(1, 0);
    bus(0, 8'hCD, 32'h12);
    bus(0, 8'hC8, 32'h86);
    bus(1, 8'hCC, 32'h00);
    bus(1, 8'hCF, 32'h02);
    bus(1, 8'hC8, 32'h08);
    pulse(0, 1);
    bus(0, 8'hC8, 32'h48);
    bus(0, 8'hCC, 32'h34);
    cmp(irq, 32'h1);
    bus(1, 8'hCE, 32'h02);
    bus(1, 8'hC8, 32'h08);
    bus(1, 8'hC9, 32'h01);
    pulse(0, 1);
    bus(0, 8'hC8, 32'h08);
    cmp(irq, 32'h0);
    bus(1, 8'hC9, 32'h00);
    bus(1, 8'hCC, 32'h56);
    bus(1, 8'hC8, 32'h09);
    pulse(0, 1);
    bus(0, 8'hCA, 32'h56);
    bus(0, 8'hC8, 32'h49);
    wrap_up();
  end
endmodule : testbench
